// >>> hw/phy_id_and_autoneg_ability_regs.sv
// What this block does
// - ident registers return vendor identifier bits 3-24
// - fixed six-bit model number, read-only
// - fixed four-bit revision, read-only
// - advert top bit enables next page function
// - writable acknowledge bit in transmitted word
// - fault advert bit signals fault to partner
// - advert bits twelve, eleven read zero
// - pause bit advertises flow control wish
// - technology bits advertise matching abilities
// - writable selector, resets to 802.3 code
// - partner top bit shows next page wish
// - partner receipt bit shows partner acknowledge
// - partner fault bit shows partner fault
// - partner technology bits read-only, advert layout
// - partner low bits hold received selector
// - partner valid only after completion flag
`include "phy_ability_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module phy_id_and_autoneg_ability_regs
#(
  // arbitrary identity values, not those of any real part
  parameter logic [21:0] OUI_BITS = 22'h2A5A5A,
  parameter logic [5:0] MODEL_NUM = 6'h15,
  parameter logic [3:0] REV_NUM = 4'h1
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // management register port
  input wire phy_ability_pkg::mgmt_req_t mgmt_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rd_valid_out,
  // arbitration side, received words
  input wire logic [15:0] lcw_rx_word_in,
  input wire logic lcw_accept_in,
  input wire logic an_restart_in,
  input wire logic an_done_in,
  // arbitration side, local view
  output phy_ability_pkg::advert_t tx_lcw_out,
  output logic next_page_en_out,
  output phy_ability_pkg::partner_t partner_out,
  output logic negotiation_complete_flag_out
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ----------------------------------------
  // register select
  // ----------------------------------------
  // one bit per mapped word; all clear for an unmapped address
  function automatic logic [3:0] reg_select(input logic [4:0] addr);
    reg_select = 4'h0;
    reg_select[`SEL_IDENT_HIGH] = hit(addr, `OFS_IDENT_HIGH);
    reg_select[`SEL_IDENT_LOW] = hit(addr, `OFS_IDENT_LOW);
    reg_select[`SEL_ADVERT] = hit(addr, `OFS_ADVERT);
    reg_select[`SEL_PARTNER] = hit(addr, `OFS_PARTNER);
  endfunction

  logic [15:0] advert_ff;
  logic [15:0] nxt_advert;
  logic [15:0] partner_ff;
  logic [15:0] nxt_partner;
  logic done_ff;
  logic nxt_done;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic rd_valid_ff;
  logic [15:0] ident_high;
  logic [15:0] ident_low;
  logic adv_wr;
  logic [3:0] sel;
  phy_ability_pkg::advert_t wr_view;
  phy_ability_pkg::advert_t wr_fields;
  phy_ability_pkg::partner_t partner_view;

  // ----------------------------------------
  // identification words
  // ----------------------------------------
  assign ident_high = OUI_BITS[`OUI_HIGH_HI:`OUI_HIGH_LO];
  always_comb
  begin
    ident_low = `ZERO_WORD;
    ident_low[`IDL_OUI_HI:`IDL_OUI_LO] = OUI_BITS[`OUI_LOW_HI:`OUI_LOW_LO];
    ident_low[`IDL_MODEL_HI:`IDL_MODEL_LO] = MODEL_NUM;
    ident_low[`IDL_REV_HI:`IDL_REV_LO] = REV_NUM;
  end

  // ----------------------------------------
  // advertisement register
  // ----------------------------------------
  assign sel = reg_select(mgmt_req_in.addr);
  assign adv_wr = mgmt_req_in.wr_en && sel[`SEL_ADVERT];
  assign wr_view = phy_ability_pkg::advert_t'(mgmt_req_in.wdata);

  // field by field, so each advertised ability is stored where it is sent
  always_comb
  begin
    wr_fields = phy_ability_pkg::advert_t'(`ZERO_WORD);
    wr_fields.next_page_enable = wr_view.next_page_enable;
    wr_fields.ack = wr_view.ack;
    wr_fields.local_fault_advert = wr_view.local_fault_advert;
    // reserved pair is never stored, so it always reads zero
    wr_fields.reserved = 2'h0;
    wr_fields.pause_advert = wr_view.pause_advert;
    // stored as written; keeping it clear is up to software
    wr_fields.four_pair_advert = wr_view.four_pair_advert;
    wr_fields.fast_full_duplex_advert = wr_view.fast_full_duplex_advert;
    wr_fields.fast_half_advert = wr_view.fast_half_advert;
    wr_fields.slow_full_duplex_advert = wr_view.slow_full_duplex_advert;
    wr_fields.slow_half_advert = wr_view.slow_half_advert;
    wr_fields.selector = wr_view.selector;
  end

  always_comb
  begin
    nxt_advert = advert_ff;
    if (adv_wr)
    begin
      // the mask repeats the reserved clear as a second guard
      nxt_advert = wr_fields & `ADVERT_WR_MASK;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      advert_ff <= `ADVERT_RESET;
    end
    else
    begin
      advert_ff <= nxt_advert;
    end
  end

  // transmitted word carries the whole advertisement
  assign tx_lcw_out = phy_ability_pkg::advert_t'(advert_ff);
  assign next_page_en_out = tx_lcw_out.next_page_enable;

  // ----------------------------------------
  // partner base page capture
  // ----------------------------------------
  always_comb
  begin
    nxt_partner = partner_ff;
    if (lcw_accept_in)
    begin
      nxt_partner = lcw_rx_word_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      partner_ff <= `PARTNER_RESET;
    end
    else
    begin
      partner_ff <= nxt_partner;
    end
  end

  assign partner_view = phy_ability_pkg::partner_t'(partner_ff);

  // ----------------------------------------
  // partner fields
  // ----------------------------------------
  // readable at any time; trust it only while the completion flag is set
  always_comb
  begin
    partner_out = phy_ability_pkg::partner_t'(`ZERO_WORD);
    partner_out.partner_extra_pages = partner_view.partner_extra_pages;
    partner_out.partner_receipt_flag = partner_view.partner_receipt_flag;
    partner_out.partner_fault_flag = partner_view.partner_fault_flag;
    partner_out.partner_capability_field = partner_view.partner_capability_field;
    partner_out.partner_protocol_kind = partner_view.partner_protocol_kind;
  end

  // ----------------------------------------
  // completion flag
  // ----------------------------------------
  always_comb
  begin
    nxt_done = done_ff;
    if (an_restart_in)
    begin
      nxt_done = 1'b0;
    end
    // completion in the restart cycle still sets the flag
    if (an_done_in)
    begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= nxt_done;
    end
  end

  assign negotiation_complete_flag_out = done_ff;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb
  begin
    nxt_rdata = rdata_ff;
    // a read in the cycle of a write returns the word before the write
    if (mgmt_req_in.rd_en)
    begin
      unique case (1'b1)
        sel[`SEL_IDENT_HIGH]:
        begin
          nxt_rdata = ident_high;
        end
        sel[`SEL_IDENT_LOW]:
        begin
          nxt_rdata = ident_low;
        end
        sel[`SEL_ADVERT]:
        begin
          nxt_rdata = advert_ff;
        end
        sel[`SEL_PARTNER]:
        begin
          nxt_rdata = partner_ff;
        end
        default:
        begin
          // unmapped words read as zero
          nxt_rdata = `ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      rdata_ff <= `RDATA_RESET;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= mgmt_req_in.rd_en;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_rd_valid_out = rd_valid_ff;

endmodule // phy_id_and_autoneg_ability_regs

`default_nettype wire

// >>> hw/phy_ability_regs.svh
`ifndef PHY_ABILITY_REGS_SVH
`define PHY_ABILITY_REGS_SVH

// ----------------------------------------
// register offsets on the management port
// ----------------------------------------
`define OFS_IDENT_HIGH 5'h02
`define OFS_IDENT_LOW 5'h03
`define OFS_ADVERT 5'h04
`define OFS_PARTNER 5'h05

// ----------------------------------------
// register select bit positions
// ----------------------------------------
`define SEL_IDENT_HIGH 0
`define SEL_IDENT_LOW 1
`define SEL_ADVERT 2
`define SEL_PARTNER 3

// ----------------------------------------
// field positions
// ----------------------------------------
`define IDL_OUI_HI 15
`define IDL_OUI_LO 10
`define IDL_MODEL_HI 9
`define IDL_MODEL_LO 4
`define IDL_REV_HI 3
`define IDL_REV_LO 0
`define OUI_HIGH_HI 21
`define OUI_HIGH_LO 6
`define OUI_LOW_HI 5
`define OUI_LOW_LO 0

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define ADVERT_RESET 16'h01E1
`define ADVERT_WR_MASK 16'hE7FF
`define PARTNER_RESET 16'h0000
`define RDATA_RESET 16'h0000
`define ZERO_WORD 16'h0000

`endif

// >>> hw/phy_ability_pkg.sv
package phy_ability_pkg;

  // ----------------------------------------
  // local ability advertisement layout
  // ----------------------------------------
  typedef struct packed {
    logic next_page_enable;
    logic ack;
    logic local_fault_advert;
    logic [1:0] reserved;
    logic pause_advert;
    logic four_pair_advert;
    logic fast_full_duplex_advert;
    logic fast_half_advert;
    logic slow_full_duplex_advert;
    logic slow_half_advert;
    logic [4:0] selector;
  } advert_t;

  // ----------------------------------------
  // partner base page layout
  // ----------------------------------------
  typedef struct packed {
    logic partner_extra_pages;
    logic partner_receipt_flag;
    logic partner_fault_flag;
    logic [7:0] partner_capability_field;
    logic [4:0] partner_protocol_kind;
  } partner_t;

  // ----------------------------------------
  // management register request
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] addr;
    logic wr_en;
    logic rd_en;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage

// >>> testbench/phy_ability_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module phy_ability_regs_assertions
#(
  parameter logic [21:0] OUI_BITS = 22'h2A5A5A
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // watched ports
  input wire phy_ability_pkg::mgmt_req_t mgmt_req_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rd_valid_out,
  input wire logic [15:0] lcw_rx_word_in,
  input wire logic lcw_accept_in,
  input wire logic an_restart_in,
  input wire logic an_done_in,
  input wire phy_ability_pkg::advert_t tx_lcw_out,
  input wire phy_ability_pkg::partner_t partner_out,
  input wire logic negotiation_complete_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic rd2 = mgmt_req_in.rd_en && mgmt_req_in.addr == 5'h02;
  wire logic wr4 = mgmt_req_in.wr_en && mgmt_req_in.addr == 5'h04;
  a_read_answer: assert property (mgmt_req_in.rd_en |=> reg_rd_valid_out)
    else $error("read not answered");
  a_ident_high: assert property (rd2 |=> reg_rdata_out == OUI_BITS[21:6])
    else $error("ident high wrong");
  a_advert_write: assert property (wr4 |=> tx_lcw_out == ($past(mgmt_req_in.wdata) & 16'hE7FF))
    else $error("advert write wrong");
  a_reserved_zero: assert property (tx_lcw_out.reserved == 2'h0)
    else $error("reserved bits set");
  a_word_capture: assert property (lcw_accept_in |=> partner_out == $past(lcw_rx_word_in))
    else $error("partner word not captured");
  a_partner_hold: assert property (!lcw_accept_in |=> $stable(partner_out))
    else $error("partner word changed");
  a_done_sets: assert property (an_done_in |=> negotiation_complete_flag_out)
    else $error("flag not set");
  a_restart_clears: assert property (an_restart_in && !an_done_in |=> !negotiation_complete_flag_out)
    else $error("flag not cleared");
endmodule // phy_ability_regs_assertions
bind phy_id_and_autoneg_ability_regs phy_ability_regs_assertions #(.OUI_BITS(OUI_BITS)) u_chk (.*);
`default_nettype wire

// >>> testbench/mgmt_station_model.sv
`timescale 1ns/100ps
`default_nettype none
module mgmt_station_model
(
  // clock
  input wire logic clk_in,
  // register port
  output var phy_ability_pkg::mgmt_req_t req_out,
  input wire logic [15:0] rdata_in,
  input wire logic valid_in
);
  initial req_out = '0;
  // one access; idle lines show inverted junk
  task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge clk_in);
    #1;
    req_out = '{addr: a, wr_en: w, rd_en: !w, wdata: d};
    @(posedge clk_in);
    #1;
    // read answer stands for the one cycle after the taking edge
    q = (valid_in === 1'b1) ? rdata_in : 16'hXXXX;
    req_out = '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wdata: ~d};
  endtask
endmodule // mgmt_station_model
`default_nettype wire

// >>> testbench/phy_id_and_autoneg_ability_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module phy_id_and_autoneg_ability_regs_test;
  localparam logic [21:0] OUI = 22'h2A5A5A;
  localparam logic [5:0] MOD = 6'h15;
  localparam logic [3:0] REV = 4'h1;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic accept = 1'b0;
  logic restart = 1'b0;
  logic done = 1'b0;
  logic [15:0] lcw = 16'h0000;
  logic [15:0] lfsr = 16'h3264;
  logic [15:0] adv = 16'h01E1;
  logic [15:0] par = 16'h0000;
  logic [15:0] q, rdata;
  logic valid, np, flag;
  logic [4:0] ads [5] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h1F};
  logic [2:0] fl [4] = '{3'b101, 3'b010, 3'b111, 3'b010};
  phy_ability_pkg::mgmt_req_t req;
  phy_ability_pkg::advert_t tx;
  phy_ability_pkg::partner_t pout;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 clk_in = ~clk_in;
  phy_id_and_autoneg_ability_regs #(.OUI_BITS(OUI), .MODEL_NUM(MOD), .REV_NUM(REV)) i_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .mgmt_req_in(req), .reg_rdata_out(rdata),
    .reg_rd_valid_out(valid), .lcw_rx_word_in(lcw), .lcw_accept_in(accept),
    .an_restart_in(restart), .an_done_in(done), .tx_lcw_out(tx), .next_page_en_out(np),
    .partner_out(pout), .negotiation_complete_flag_out(flag));
  mgmt_station_model i_mgmt (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .valid_in(valid));
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] expect_rd(input logic [4:0] a);
    case (a)
      5'h02: return OUI[21:6];
      5'h03: return {OUI[5:0], MOD, REV};
      5'h04: return adv;
      5'h05: return par;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    chk(tx, 16'h01E1);
    foreach (ads[i])
    begin
      lfsr = step(lfsr);
      if (ads[i] != 5'h04)
        i_mgmt.access(ads[i], 1'b1, lfsr, q);
      i_mgmt.access(ads[i], 1'b0, 16'h0000, q);
      chk(q, expect_rd(ads[i]));
    end
    $display("test 1 done");
    repeat (24)
    begin
      lfsr = step(lfsr);
      adv = lfsr & 16'hE5FF;
      i_mgmt.access(5'h04, 1'b1, adv | 16'h1800, q);
      chk(tx, adv);
      chk({15'h0, np}, {15'h0, adv[15]});
      i_mgmt.access(5'h04, 1'b0, 16'h0000, q);
      chk(q, adv);
    end
    $display("test 2 done");
    repeat (8)
    begin
      lfsr = step(lfsr);
      lcw = lfsr;
      accept = 1'b1;
      @(posedge clk_in);
      #1;
      lfsr = step(lfsr);
      lcw = lfsr;
      par = lfsr;
      @(posedge clk_in);
      #1;
      accept = 1'b0;
      lcw = ~par;
      chk(pout, par);
      i_mgmt.access(5'h05, 1'b1, ~par, q);
      i_mgmt.access(5'h05, 1'b0, 16'h0000, q);
      chk(q, par);
    end
    $display("test 3 done");
    foreach (fl[i])
    begin
      done = fl[i][2];
      restart = fl[i][1];
      @(posedge clk_in);
      #1;
      done = 1'b0;
      restart = 1'b0;
      chk({15'h0, flag}, {15'h0, fl[i][0]});
    end
    $display("test 4 done");
    tally_and_finish();
  end
endmodule // phy_id_and_autoneg_ability_regs_test
`default_nettype wire
